// >>> rtl/per_defines.vh
// Constants for the exit/reverse paper path controller.
// Included by the controller; holds definitions only.
`ifndef PER_DEFINES_VH
`define PER_DEFINES_VH

// Register byte offsets
`define PER_CTRL_OFF 8'h00
`define PER_STAT_OFF 8'h04
`define PER_EXIT_OFF 8'h08
`define PER_REVP_OFF 8'h0c
// Control fields
`define PER_CTRL_RUN 0
`define PER_CTRL_DUPLEX 1
`define PER_CTRL_EXIT_RUN 2
`define PER_CTRL_CNT_LSB 8
`define PER_CTRL_RST 32'h0000_0000
// Sheet count above which reversing is used
`define PER_REVERSE_MIN_SHEETS 8'h02
// Timing, in microseconds, and derived cycles at 100 MHz
`define PER_CLK_MHZ 100
`define PER_SWITCHBACK_US 200
`define PER_SWITCHBACK_CYC (`PER_SWITCHBACK_US * `PER_CLK_MHZ)
`define PER_HIGH_HALF_CYC 16'd500
`define PER_NORM_HALF_CYC 16'd1000
`define PER_EXIT_ACCEL_STEPS 8'd32
`define PER_EXIT_RST_PERIOD 16'd1000
`define PER_EXIT_MIN_PERIOD 16'd400

`endif

// >>> rtl/per_ctrl.v
// Exit/reverse paper path controller with AXI4-Lite register access.
// Assumes sensors and bus synchronous to CORE_CLK; stepper drivers outside.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "per_defines.vh"

module per_ctrl #(
  parameter SWITCHBACK_CYC = `PER_SWITCHBACK_CYC,
  parameter [15:0] HIGH_HALF = `PER_HIGH_HALF_CYC,
  parameter [15:0] NORM_HALF = `PER_NORM_HALF_CYC,
  parameter [7:0] ACCEL_STEPS = `PER_EXIT_ACCEL_STEPS
) (
  input wire CORE_CLK,
  input wire RESETN,
  input wire CLK_EN,
  input wire FUSER_TRAILING_SENSOR,
  input wire REVERSE_PATH_SENSOR_ONE,
  input wire REVERSE_PATH_SENSOR_TWO,
  input wire SECOND_PASS,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg PATH_GATE_SOLENOID,
  output reg EXIT_PHASE_A,
  output reg EXIT_PHASE_B,
  output reg EXIT_PHASE_C,
  output reg EXIT_PHASE_D,
  output reg EXIT_SPEED_MODE,
  output reg REVERSE_STEP_CLOCK,
  output reg REVERSE_DRIVE_ENABLE_N,
  output reg REVERSE_SPEED_MODE,
  output reg REVERSE_DIRECTION_SELECT
);

  localparam ST_IDLE = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_HIGH = 3'd2;
  localparam ST_BACK = 3'd3;
  localparam ST_DUPX = 3'd4;

  // Register offsets held at bus width so the word index is a plain slice
  localparam [7:0] CTRL_OFF = `PER_CTRL_OFF;
  localparam [7:0] STAT_OFF = `PER_STAT_OFF;
  localparam [7:0] EXIT_OFF = `PER_EXIT_OFF;
  localparam [7:0] REVP_OFF = `PER_REVP_OFF;

  reg [31:0] ctrl_q;
  reg [15:0] exit_target_q;
  reg [2:0] state_q;
  reg [31:0] delay_q;
  reg [15:0] rev_cnt_q;
  reg [15:0] rev_half_q;
  reg trail_q;
  reg [15:0] exit_cnt_q;
  reg [15:0] exit_period_q;
  reg [1:0] exit_phase_q;
  reg [7:0] exit_ramp_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;

  wire run = ctrl_q[`PER_CTRL_RUN];
  wire duplex = ctrl_q[`PER_CTRL_DUPLEX];
  wire exit_run = ctrl_q[`PER_CTRL_EXIT_RUN];
  wire [7:0] sheets = ctrl_q[`PER_CTRL_CNT_LSB +: 8];
  wire reverse_needed = duplex | (sheets > `PER_REVERSE_MIN_SHEETS);
  wire trail_pass = trail_q & ~FUSER_TRAILING_SENSOR;
  wire rev_moving = (state_q != ST_IDLE) && (state_q != ST_WAIT);
  wire [31:0] sb_cyc = SWITCHBACK_CYC;
  wire exit_at_target = (exit_period_q == exit_target_q);
  wire exit_active = exit_run | (exit_period_q != `PER_EXIT_RST_PERIOD);

  ////////////////////////////////////////////////////////////////////////
  // Register bus: write path takes address and data in either order
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      ctrl_q <= `PER_CTRL_RST;
      exit_target_q <= `PER_EXIT_RST_PERIOD;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      if (S_AXI_AWVALID && !aw_hold_q && !S_AXI_AWREADY && !S_AXI_BVALID) begin
        S_AXI_AWREADY <= 1'b1;
        aw_hold_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_hold_q && !S_AXI_WREADY && !S_AXI_BVALID) begin
        S_AXI_WREADY <= 1'b1;
        w_hold_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
      end
      if (aw_hold_q && w_hold_q && !S_AXI_BVALID) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= 2'b00;
        // Control takes each strobed low byte; exit target is written only when both low strobes are set
        if (aw_addr_q[7:2] == CTRL_OFF[7:2]) begin
          if (S_AXI_WSTRB[0]) ctrl_q[7:0] <= w_data_q[7:0];
          if (S_AXI_WSTRB[1]) ctrl_q[15:8] <= w_data_q[15:8];
        end else if (aw_addr_q[7:2] == EXIT_OFF[7:2]) begin
          // Floor keeps the exit motor from being overdriven
          if (&S_AXI_WSTRB[1:0])
            exit_target_q <= (w_data_q[15:0] < `PER_EXIT_MIN_PERIOD) ? `PER_EXIT_MIN_PERIOD : w_data_q[15:0];
        end else if (aw_addr_q[7:2] != STAT_OFF[7:2] && aw_addr_q[7:2] != REVP_OFF[7:2]) begin
          S_AXI_BRESP <= 2'b10;
        end
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Register bus: read path, data valid in the same cycle the address is accepted
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (CLK_EN) begin
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= 2'b00;
        case (S_AXI_ARADDR[7:2])
          CTRL_OFF[7:2]: S_AXI_RDATA <= {16'h0000, ctrl_q[15:0]};
          STAT_OFF[7:2]: S_AXI_RDATA <= {20'h00000, REVERSE_PATH_SENSOR_TWO, REVERSE_PATH_SENSOR_ONE,
                                              PATH_GATE_SOLENOID, REVERSE_DIRECTION_SELECT,
                                              REVERSE_DRIVE_ENABLE_N, REVERSE_SPEED_MODE, EXIT_SPEED_MODE,
                                              reverse_needed, 1'b0, state_q};
          EXIT_OFF[7:2]: S_AXI_RDATA <= {16'h0000, exit_target_q};
          REVP_OFF[7:2]: S_AXI_RDATA <= {16'h0000, rev_half_q};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b10;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sheet sequence: gate, speed change, switchback, duplex hand-off
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      delay_q <= 32'h0000_0000;
      trail_q <= 1'b0;
      rev_half_q <= NORM_HALF;
      PATH_GATE_SOLENOID <= 1'b0;
      REVERSE_DRIVE_ENABLE_N <= 1'b1;
      REVERSE_DIRECTION_SELECT <= 1'b0;
    end else if (CLK_EN) begin
      trail_q <= FUSER_TRAILING_SENSOR;
      // Energized only for straight exit or duplex second pass
      // Straight exit waits until the reverse motor is parked, so the two never overlap
      PATH_GATE_SOLENOID <= run & (SECOND_PASS | (~reverse_needed & (state_q == ST_IDLE)));
      case (state_q)
        ST_IDLE: begin
          REVERSE_DRIVE_ENABLE_N <= 1'b1;
          rev_half_q <= NORM_HALF;
          REVERSE_DIRECTION_SELECT <= 1'b0;
          if (run && reverse_needed && !SECOND_PASS) state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          REVERSE_DRIVE_ENABLE_N <= 1'b0;
          REVERSE_DIRECTION_SELECT <= 1'b0;
          rev_half_q <= NORM_HALF;
          if (!run || !reverse_needed) state_q <= ST_IDLE;
          else if (trail_pass) begin
            rev_half_q <= HIGH_HALF;
            delay_q <= 32'h0000_0000;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          delay_q <= delay_q + 32'h0000_0001;
          if (delay_q >= sb_cyc - 32'h0000_0001) begin
            REVERSE_DIRECTION_SELECT <= 1'b1;
            state_q <= duplex ? ST_DUPX : ST_BACK;
          end
        end
        ST_BACK: begin
          // High speed kept until the sheet clears the reverse sensor
          rev_half_q <= HIGH_HALF;
          if (!REVERSE_PATH_SENSOR_TWO) state_q <= ST_WAIT;
        end
        ST_DUPX: begin
          if (!REVERSE_PATH_SENSOR_TWO) begin
            rev_half_q <= NORM_HALF;
            state_q <= ST_WAIT;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Reverse step clock: period compared every cycle, so a change applies to the half period in progress
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rev_cnt_q <= 16'h0000;
      REVERSE_STEP_CLOCK <= 1'b0;
      REVERSE_SPEED_MODE <= 1'b0;
    end else if (CLK_EN) begin
      if (!rev_moving) begin
        rev_cnt_q <= 16'h0000;
        REVERSE_STEP_CLOCK <= 1'b0;
      end else if (rev_cnt_q >= rev_half_q - 16'h0001) begin
        rev_cnt_q <= 16'h0000;
        REVERSE_STEP_CLOCK <= ~REVERSE_STEP_CLOCK;
      end else begin
        rev_cnt_q <= rev_cnt_q + 16'h0001;
      end
      // Low on the speed change, high through the reversal and hand-off
      REVERSE_SPEED_MODE <= ~REVERSE_DRIVE_ENABLE_N & rev_moving & (state_q != ST_HIGH);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exit motor: four-phase sequence with linear period ramp
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      exit_cnt_q <= 16'h0000;
      exit_period_q <= `PER_EXIT_RST_PERIOD;
      exit_phase_q <= 2'd0;
      exit_ramp_q <= 8'h00;
      EXIT_PHASE_A <= 1'b0;
      EXIT_PHASE_B <= 1'b0;
      EXIT_PHASE_C <= 1'b0;
      EXIT_PHASE_D <= 1'b0;
      EXIT_SPEED_MODE <= 1'b0;
    end else if (CLK_EN) begin
      if (!exit_active) begin
        exit_cnt_q <= 16'h0000;
        {EXIT_PHASE_A, EXIT_PHASE_B, EXIT_PHASE_C, EXIT_PHASE_D} <= 4'b0000;
        EXIT_SPEED_MODE <= 1'b0;
      end else if (exit_cnt_q >= exit_period_q - 16'h0001) begin
        exit_cnt_q <= 16'h0000;
        exit_phase_q <= exit_phase_q + 2'd1;
        // One phase active at a time, rotating A-B-C-D
        EXIT_PHASE_A <= (exit_phase_q == 2'd3);
        EXIT_PHASE_B <= (exit_phase_q == 2'd0);
        EXIT_PHASE_C <= (exit_phase_q == 2'd1);
        EXIT_PHASE_D <= (exit_phase_q == 2'd2);
        // Move period toward target, or up to the reset period when stopped, in ACCEL_STEPS-cycle increments
        if (!exit_run) begin
          exit_period_q <= (exit_period_q + ACCEL_STEPS >= `PER_EXIT_RST_PERIOD) ?
                           `PER_EXIT_RST_PERIOD : exit_period_q + {8'h00, ACCEL_STEPS};
        end else if (exit_period_q > exit_target_q + ACCEL_STEPS) begin
          exit_period_q <= exit_period_q - {8'h00, ACCEL_STEPS};
        end else if (exit_period_q + ACCEL_STEPS < exit_target_q) begin
          exit_period_q <= exit_period_q + {8'h00, ACCEL_STEPS};
        end else begin
          exit_period_q <= exit_target_q;
        end
        EXIT_SPEED_MODE <= exit_run & exit_at_target;
      end else begin
        exit_cnt_q <= exit_cnt_q + 16'h0001;
      end
    end
  end

endmodule // per_ctrl

// >>> testbench/per_ctrl_assertions.sv
// Checker for the paper path controller ports.
// Bound into per_ctrl; takes the instance's own parameters.
`timescale 1ns/1ns
module per_ctrl_assertions #(
  parameter SWITCHBACK_CYC = 20,
  parameter [15:0] NORM_HALF = 16'd8
) (
  input wire CORE_CLK,
  input wire RESETN,
  input wire FUSER_TRAILING_SENSOR,
  input wire SECOND_PASS,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire PATH_GATE_SOLENOID,
  input wire EXIT_PHASE_A,
  input wire EXIT_PHASE_B,
  input wire EXIT_PHASE_C,
  input wire EXIT_PHASE_D,
  input wire EXIT_SPEED_MODE,
  input wire REVERSE_STEP_CLOCK,
  input wire REVERSE_DRIVE_ENABLE_N,
  input wire REVERSE_SPEED_MODE,
  input wire REVERSE_DIRECTION_SELECT
);
  localparam int SB_LO = SWITCHBACK_CYC - 10;
  localparam int SB_HI = SWITCHBACK_CYC - 3;
  wire [3:0] ph = {EXIT_PHASE_A, EXIT_PHASE_B, EXIT_PHASE_C, EXIT_PHASE_D};
  reg [15:0] half_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Cycles since the last rising step edge; the high phase must not outlast a normal half period
  // Low phases are not measured: the clock parks low for any time between sheets
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      half_q <= 16'd0;
    else if (REVERSE_DRIVE_ENABLE_N || $rose(REVERSE_STEP_CLOCK))
      half_q <= 16'd0;
    else
      half_q <= half_q + 16'd1;
  end
  ////////////////////////////////////////
  sequence s_quiet;
    !REVERSE_DIRECTION_SELECT [*8];
  endsequence
  sequence s_flip;
    $rose(REVERSE_DIRECTION_SELECT);
  endsequence
  property p_switch;
    $fell(FUSER_TRAILING_SENSOR) && !REVERSE_DRIVE_ENABLE_N |-> s_quiet ##[SB_LO:SB_HI] s_flip;
  endproperty
  a_switch: assert property (p_switch) else $error("switchback mistimed");
  property p_gate;
    !REVERSE_DRIVE_ENABLE_N && !SECOND_PASS && !$past(SECOND_PASS) |-> !PATH_GATE_SOLENOID;
  endproperty
  a_gate: assert property (p_gate) else $error("gate energized while reversing");
  property p_rest;
    $rose(RESETN) |-> !PATH_GATE_SOLENOID && REVERSE_DRIVE_ENABLE_N;
  endproperty
  a_rest: assert property (p_rest) else $error("bad state after reset");
  property p_second;
    $past(SECOND_PASS) && !$past(REVERSE_DRIVE_ENABLE_N) && !REVERSE_DRIVE_ENABLE_N |-> PATH_GATE_SOLENOID;
  endproperty
  a_second: assert property (p_second) else $error("second pass not sent to exit");
  property p_dir;
    REVERSE_DIRECTION_SELECT |-> !REVERSE_DRIVE_ENABLE_N;
  endproperty
  a_dir: assert property (p_dir) else $error("reverse set with driver off");
  property p_rmode;
    REVERSE_SPEED_MODE |-> !REVERSE_DRIVE_ENABLE_N;
  endproperty
  a_rmode: assert property (p_rmode) else $error("speed mode with driver off");
  property p_phase;
    $onehot0(ph);
  endproperty
  a_phase: assert property (p_phase) else $error("exit phases overlap");
  property p_xmode;
    EXIT_SPEED_MODE |-> $onehot(ph);
  endproperty
  a_xmode: assert property (p_xmode) else $error("constant speed without phase");
  property p_step;
    $fell(REVERSE_STEP_CLOCK) && !$past(REVERSE_DRIVE_ENABLE_N) |-> half_q <= NORM_HALF;
  endproperty
  a_step: assert property (p_step) else $error("step half period too long");
  property p_bresp;
    $fell(S_AXI_BVALID) |-> $past(S_AXI_BREADY);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response dropped early");
  property p_rresp;
    $fell(S_AXI_RVALID) |-> $past(S_AXI_RREADY);
  endproperty
  a_rresp: assert property (p_rresp) else $error("read data dropped early");
endmodule // per_ctrl_assertions

bind per_ctrl per_ctrl_assertions #(.SWITCHBACK_CYC(SWITCHBACK_CYC), .NORM_HALF(NORM_HALF)) u_chk (
  .CORE_CLK, .RESETN, .FUSER_TRAILING_SENSOR, .SECOND_PASS, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_RVALID, .S_AXI_RREADY, .PATH_GATE_SOLENOID, .EXIT_PHASE_A, .EXIT_PHASE_B, .EXIT_PHASE_C,
  .EXIT_PHASE_D, .EXIT_SPEED_MODE, .REVERSE_STEP_CLOCK, .REVERSE_DRIVE_ENABLE_N, .REVERSE_SPEED_MODE,
  .REVERSE_DIRECTION_SELECT);

// >>> testbench/per_partner.sv
// Model of the reverse path: sensors and the reverse motor driver.
// Sheet is placed by the bench; it leaves after three reverse steps.
`timescale 1ns/1ns
module per_partner (
  input wire clk,
  input wire rst_n,
  input wire sheet,
  input wire step,
  input wire en_n,
  input wire dir,
  output wire fuser,
  output wire s_one,
  output reg s_two
);
  reg step_q;
  reg [3:0] rev_q;
  assign fuser = sheet;
  assign s_one = s_two;
  // Driver steps only when enabled; high direction backs the sheet out
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
      rev_q <= 4'h0;
      s_two <= 1'b0;
    end else begin
      step_q <= step;
      if (rev_q == 4'h3)
        s_two <= 1'b0;
      if (sheet) begin
        s_two <= 1'b1;
        rev_q <= 4'h0;
      end else if (!en_n && dir && step && !step_q)
        rev_q <= rev_q + 4'h1;
    end
  end
endmodule // per_partner

// >>> testbench/per_ctrl_test.sv
// Self-checking bench for the paper path controller.
// Short counts by parameter; checker bound from its own file.
`timescale 1ns/1ns
`include "per_defines.vh"
module per_ctrl_test;
  localparam SW = 20;
  localparam [15:0] HH = 16'd4;
  localparam [15:0] NH = 16'd8;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] rs;} per_row_t;
  logic clk = 0, rst_n = 0, sheet = 0, second = 0, clk_en = 1;
  logic awv = 0, wv = 0, arv = 0, bready = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [1:0] r;
  wire awr, wrdy, bv, arr, rv, gate, xmode, step, en_n, rmode, dir, fs, s1, s2;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] ph;
  int fail_count = 0, n_compared = 0, i, n;
  per_row_t rows[3];
  always #5 clk = ~clk;
  // Coarse ramp steps keep the exit motor's run-up to a few thousand cycles
  per_ctrl #(.SWITCHBACK_CYC(SW), .HIGH_HALF(HH), .NORM_HALF(NH), .ACCEL_STEPS(8'd100)) uut (
    .CORE_CLK(clk), .RESETN(rst_n), .CLK_EN(clk_en), .FUSER_TRAILING_SENSOR(fs),
    .REVERSE_PATH_SENSOR_ONE(s1), .REVERSE_PATH_SENSOR_TWO(s2), .SECOND_PASS(second),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .PATH_GATE_SOLENOID(gate), .EXIT_PHASE_A(ph[3]), .EXIT_PHASE_B(ph[2]),
    .EXIT_PHASE_C(ph[1]), .EXIT_PHASE_D(ph[0]), .EXIT_SPEED_MODE(xmode), .REVERSE_STEP_CLOCK(step),
    .REVERSE_DRIVE_ENABLE_N(en_n), .REVERSE_SPEED_MODE(rmode), .REVERSE_DIRECTION_SELECT(dir));
  per_partner u_far (.clk(clk), .rst_n(rst_n), .sheet(sheet), .step(step), .en_n(en_n),
    .dir(dir), .fuser(fs), .s_one(s1), .s_two(s2));
  ////////////////////////////////////////
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input [7:0] a, input [31:0] v, output [1:0] rs);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (bv !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do @(posedge clk); while (rv !== 1'b1);
    v = rdata;
    rs = rresp;
    arv <= 0;
    rready <= 0;
  endtask
  task automatic close_out;
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Hang guard, far beyond the few thousand cycles needed
  initial begin
    #500000;
    fail_count++;
    close_out();
  end
  initial begin
    rows[0] = '{`PER_CTRL_OFF, 32'h0000_0305, 32'h0000_0305, 2'b00};
    rows[1] = '{`PER_EXIT_OFF, 32'h0000_0190, 32'h0000_0190, 2'b00};
    rows[2] = '{8'h10, 32'h0000_0055, 32'h0000_0000, 2'b10};
    repeat (20) @(posedge clk);
    rst_n <= 1;
    chk({gate, en_n, ph}, 6'h10);
    for (i = 0; i < 3; i++) begin
      wr(rows[i].a, rows[i].w, r);
      chk(r, rows[i].rs);
      rd(rows[i].a, d, r);
      chk(d, rows[i].e);
      chk(r, rows[i].rs);
    end
    // Single-sided then duplex sheet through the switchback
    for (i = 0; i < 2; i++) begin
      wr(`PER_CTRL_OFF, 32'h0000_0305 | (i << 1), r);
      repeat (3) @(posedge clk);
      chk({gate, en_n}, 2'b00);
      sheet <= 1;
      repeat (10) @(posedge clk);
      sheet <= 0;
      n = 0;
      do begin @(posedge clk); n++; end while (dir !== 1'b1 && n < 100);
      chk(n >= SW && n <= SW + 4, 1);
      rd(`PER_REVP_OFF, d, r);
      chk(d, HH);
      chk(rmode, 1);
      n = 0;
      do begin @(posedge clk); n++; end while (dir !== 1'b0 && n < 300);
      chk(n < 300, 1);
      rd(`PER_REVP_OFF, d, r);
      chk(d, NH);
    end
    second <= 1;
    repeat (3) @(posedge clk);
    chk(gate, 1);
    second <= 0;
    wr(`PER_CTRL_OFF, 32'h0000_0205, r);
    repeat (3) @(posedge clk);
    chk({gate, en_n}, 2'b11);
    n = 0;
    do begin @(posedge clk); n++; end while (xmode !== 1'b1 && n < 20000);
    chk(xmode, 1);
    chk($onehot(ph), 1);
    // Enable low for longer than a step period: the phases must not move
    d = ph;
    clk_en <= 0;
    repeat (500) @(posedge clk);
    chk(ph, d);
    clk_en <= 1;
    close_out();
  end
endmodule // per_ctrl_test
